// file: hdl/serial_port.sv
// Asynchronous serial port with 8-bit and 9-bit frames and its control/status register.
// Assumes rxd_in is already synchronous to clk_in and an Avalon-MM master with waitrequest.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

module serial_port #(
   parameter int OVS_DIV = serial_pkg::OVS_DIV
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [3:0]  avs_byteenable_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Serial line and interrupt
   input  wire logic        rxd_in,
   output logic             txd_out,
   output logic             irq_out
);
   if (OVS_DIV < 2) begin : g_bad_div
      $error("serial_port: OVS_DIV must be at least 2");
   end

   // Word decode used by every access path
   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = (addr[3:2] == ofs[3:2]);
   endfunction

   logic ovs_tick;

   tick_divider #(.DIV(OVS_DIV)) u_div (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .tick_out (ovs_tick)
   );

   // ---------------- Bus slave ----------------
   logic        wait_r;
   logic        wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        acc;
   logic        ctrl_wr;
   logic        data_wr;
   serial_pkg::ctrl_t     ctrl_r;
   serial_pkg::ctrl_t     ctrl_nxt;
   logic [7:0]            rx_byte_r;
   logic [7:0]            rx_byte_nxt;
   serial_pkg::tx_state_t tx_st_r;
   serial_pkg::tx_state_t tx_st_nxt;

   // One wait cycle per request; the access completes on the edge that sees waitrequest low
   always_comb begin
      wait_nxt  = !((avs_read_in || avs_write_in) && wait_r);
      acc       = (avs_read_in || avs_write_in) && !wait_r;
      ctrl_wr   = acc && avs_write_in && avs_byteenable_in[0] && hit(avs_address_in, serial_pkg::CTRL_OFS);
      data_wr   = acc && avs_write_in && avs_byteenable_in[0] && hit(avs_address_in, serial_pkg::DATA_OFS);
      rdata_nxt = rdata_r;
      if (avs_read_in && wait_r) begin
         rdata_nxt = 32'h0000_0000; // Unmapped words read as zero
         if (hit(avs_address_in, serial_pkg::CTRL_OFS)) begin
            rdata_nxt[7:0] = ctrl_r;
         end else if (hit(avs_address_in, serial_pkg::DATA_OFS)) begin
            rdata_nxt[7:0] = rx_byte_r;
            rdata_nxt[serial_pkg::DATA_BUSY_BIT] = (tx_st_r != serial_pkg::TX_IDLE);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest_out = wait_r;
   assign avs_readdata_out    = rdata_r;

   // ---------------- Transmitter ----------------
   logic [3:0] tx_sub_r;
   logic [3:0] tx_sub_nxt;
   logic [3:0] tx_cnt_r;
   logic [3:0] tx_cnt_nxt;
   logic [7:0] tx_sh_r;
   logic [7:0] tx_sh_nxt;
   logic       tx_nine_r;
   logic       tx_nine_nxt;
   logic       tx_bit9_r;
   logic       tx_bit9_nxt;
   logic       txd_nxt;
   logic       tx_set;

   // Mode and ninth bit are latched at frame start so a mid-frame write cannot tear a frame
   always_comb begin
      tx_st_nxt   = tx_st_r;
      tx_sub_nxt  = tx_sub_r;
      tx_cnt_nxt  = tx_cnt_r;
      tx_sh_nxt   = tx_sh_r;
      tx_nine_nxt = tx_nine_r;
      tx_bit9_nxt = tx_bit9_r;
      txd_nxt     = txd_out;
      tx_set      = 1'b0;
      if (tx_st_r != serial_pkg::TX_IDLE && ovs_tick) begin
         tx_sub_nxt = tx_sub_r + 4'h1;
      end
      case (tx_st_r)
         serial_pkg::TX_IDLE: begin
            if (data_wr) begin // Writes while busy are dropped
               tx_st_nxt   = serial_pkg::TX_START;
               tx_sub_nxt  = 4'h0;
               tx_sh_nxt   = avs_writedata_in[7:0];
               tx_nine_nxt = ctrl_r.nine_bit_mode;
               tx_bit9_nxt = ctrl_r.transmit_ninth_bit;
               txd_nxt     = 1'b0;
            end
         end
         serial_pkg::TX_START: begin
            if (ovs_tick && tx_sub_r == serial_pkg::SUB_LAST) begin
               tx_st_nxt  = serial_pkg::TX_DATA;
               tx_cnt_nxt = 4'h0;
               txd_nxt    = tx_sh_r[0];
            end
         end
         serial_pkg::TX_DATA: begin
            if (ovs_tick && tx_sub_r == serial_pkg::SUB_LAST) begin
               tx_cnt_nxt = tx_cnt_r + 4'h1;
               tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
               txd_nxt    = tx_sh_r[1];
               if (tx_cnt_r == serial_pkg::DATA_LAST8) begin
                  if (tx_nine_r) begin
                     tx_st_nxt = serial_pkg::TX_NINTH;
                     txd_nxt   = tx_bit9_r;
                  end else begin
                     tx_st_nxt = serial_pkg::TX_STOP;
                     txd_nxt   = 1'b1;
                     tx_set    = 1'b1;
                  end
               end
            end
         end
         serial_pkg::TX_NINTH: begin
            if (ovs_tick && tx_sub_r == serial_pkg::SUB_LAST) begin
               tx_st_nxt = serial_pkg::TX_STOP;
               txd_nxt   = 1'b1;
               tx_set    = 1'b1;
            end
         end
         serial_pkg::TX_STOP: begin
            if (ovs_tick && tx_sub_r == serial_pkg::SUB_LAST) begin
               tx_st_nxt = serial_pkg::TX_IDLE;
            end
         end
         default: begin
            tx_st_nxt = serial_pkg::TX_IDLE;
            txd_nxt   = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_st_r   <= serial_pkg::TX_IDLE;
         tx_sub_r  <= 4'h0;
         tx_cnt_r  <= 4'h0;
         tx_sh_r   <= 8'h00;
         tx_nine_r <= 1'b0;
         tx_bit9_r <= 1'b0;
         txd_out   <= 1'b1;
      end else begin
         tx_st_r   <= tx_st_nxt;
         tx_sub_r  <= tx_sub_nxt;
         tx_cnt_r  <= tx_cnt_nxt;
         tx_sh_r   <= tx_sh_nxt;
         tx_nine_r <= tx_nine_nxt;
         tx_bit9_r <= tx_bit9_nxt;
         txd_out   <= txd_nxt;
      end
   end

   // ---------------- Receiver ----------------
   serial_pkg::rx_state_t rx_st_r;
   serial_pkg::rx_state_t rx_st_nxt;
   logic [3:0] rx_sub_r;
   logic [3:0] rx_sub_nxt;
   logic [3:0] rx_cnt_r;
   logic [3:0] rx_cnt_nxt;
   logic [8:0] rx_sh_r;
   logic [8:0] rx_sh_nxt;
   logic       rx_nine_r;
   logic       rx_nine_nxt;
   logic       rx_done;
   logic       ninth_val;
   logic       rx_set;

   // Start is checked again at mid-bit so a short glitch does not open a frame
   always_comb begin
      rx_st_nxt   = rx_st_r;
      rx_sub_nxt  = rx_sub_r;
      rx_cnt_nxt  = rx_cnt_r;
      rx_sh_nxt   = rx_sh_r;
      rx_nine_nxt = rx_nine_r;
      rx_done     = 1'b0;
      if (rx_st_r != serial_pkg::RX_IDLE && ovs_tick) begin
         rx_sub_nxt = rx_sub_r + 4'h1;
      end
      case (rx_st_r)
         serial_pkg::RX_IDLE: begin
            if (ctrl_r.receiver_enable_control && !rxd_in) begin
               rx_st_nxt   = serial_pkg::RX_START;
               rx_sub_nxt  = 4'h0;
               rx_nine_nxt = ctrl_r.nine_bit_mode;
            end
         end
         serial_pkg::RX_START: begin
            if (ovs_tick && rx_sub_r == serial_pkg::SUB_MID) begin
               rx_st_nxt  = rxd_in ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
               rx_sub_nxt = 4'h0;
               rx_cnt_nxt = 4'h0;
            end
         end
         serial_pkg::RX_DATA: begin
            if (ovs_tick && rx_sub_r == serial_pkg::SUB_LAST) begin
               rx_sh_nxt  = {rxd_in, rx_sh_r[8:1]};
               rx_cnt_nxt = rx_cnt_r + 4'h1;
               if (rx_cnt_r == (rx_nine_r ? serial_pkg::DATA_LAST9 : serial_pkg::DATA_LAST8)) begin
                  rx_st_nxt = serial_pkg::RX_STOP;
               end
            end
         end
         serial_pkg::RX_STOP: begin
            if (ovs_tick && rx_sub_r == serial_pkg::SUB_LAST) begin
               rx_done   = 1'b1;
               rx_st_nxt = serial_pkg::RX_IDLE;
            end
         end
         default: rx_st_nxt = serial_pkg::RX_IDLE;
      endcase
      ninth_val = rx_nine_r ? rx_sh_r[8] : rxd_in;
      rx_set    = rx_done && ctrl_r.receiver_enable_control
                  && (!ctrl_r.multiprocessor_stop_check || ninth_val);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_st_r   <= serial_pkg::RX_IDLE;
         rx_sub_r  <= 4'h0;
         rx_cnt_r  <= 4'h0;
         rx_sh_r   <= 9'h000;
         rx_nine_r <= 1'b0;
      end else begin
         rx_st_r   <= rx_st_nxt;
         rx_sub_r  <= rx_sub_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         rx_sh_r   <= rx_sh_nxt;
         rx_nine_r <= rx_nine_nxt;
      end
   end

   // ---------------- Control/status register and interrupt ----------------
   logic irq_nxt;

   // Hardware sets are applied after the software write so a set never loses to a clear
   always_comb begin
      ctrl_nxt    = ctrl_r;
      rx_byte_nxt = rx_byte_r;
      if (ctrl_wr) begin
         ctrl_nxt = avs_writedata_in[7:0];
      end
      if (tx_set) begin
         ctrl_nxt.transmit_complete_flag = 1'b1;
      end
      if (rx_set) begin
         ctrl_nxt.receive_complete_flag = 1'b1;
         ctrl_nxt.receive_ninth_bit     = ninth_val;
         rx_byte_nxt = rx_nine_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
      end
      irq_nxt = ctrl_nxt.irq_enable
                && (ctrl_nxt.transmit_complete_flag || ctrl_nxt.receive_complete_flag);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_r    <= serial_pkg::CTRL_RESET;
         rx_byte_r <= 8'h00;
         irq_out   <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         rx_byte_r <= rx_byte_nxt;
         irq_out   <= irq_nxt;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("waitrequest did not drop one cycle after request");
   a_stop_level_check: assert property (rx_done && !rx_nine_r && ctrl_r.multiprocessor_stop_check && !rxd_in
      && !ctrl_wr |=> $stable(ctrl_r.receive_ninth_bit) && $stable(rx_byte_r))
      else $error("frame with low stop bit was accepted");
   a_mp_filter: assert property (rx_done && rx_nine_r && ctrl_r.multiprocessor_stop_check && !rx_sh_r[8]
      && !ctrl_r.receive_complete_flag && !ctrl_wr |=> !ctrl_r.receive_complete_flag)
      else $error("frame with low ninth bit raised receive flag");
   a_rx_disabled: assert property (!ctrl_r.receiver_enable_control && rx_st_r == serial_pkg::RX_IDLE
      |=> rx_st_r == serial_pkg::RX_IDLE)
      else $error("receiver started while disabled");
   a_tx_ninth_out: assert property (tx_st_r == serial_pkg::TX_NINTH |-> txd_out == tx_bit9_r && tx_nine_r)
      else $error("ninth bit wrong or sent in 8-bit mode");
   a_rx_ninth_load: assert property (rx_set && !ctrl_wr |=> ctrl_r.receive_ninth_bit == $past(ninth_val)
      && ctrl_r.receive_complete_flag)
      else $error("receive ninth bit not loaded");
   a_tx_flag_stop: assert property ($rose(tx_st_r == serial_pkg::TX_STOP) |-> ctrl_r.transmit_complete_flag
      && txd_out)
      else $error("transmit flag not set at stop bit");
   a_rx_flag_set: assert property (rx_done && ctrl_r.receiver_enable_control
      && !ctrl_r.multiprocessor_stop_check |=> ctrl_r.receive_complete_flag)
      else $error("receive flag not set at stop sample");
   a_irq_follows: assert property (irq_out == (ctrl_r.irq_enable
      && (ctrl_r.transmit_complete_flag || ctrl_r.receive_complete_flag)))
      else $error("interrupt does not match flags");
   a_tx_flag_sticky: assert property (!ctrl_wr && ctrl_r.transmit_complete_flag
      |=> ctrl_r.transmit_complete_flag)
      else $error("transmit flag cleared by hardware");
   a_rx_flag_sticky: assert property (!ctrl_wr && ctrl_r.receive_complete_flag
      |=> ctrl_r.receive_complete_flag)
      else $error("receive flag cleared by hardware");
   a_rx_off_quiet: assert property (!ctrl_r.receiver_enable_control && !ctrl_r.receive_complete_flag
      && !ctrl_wr |=> !ctrl_r.receive_complete_flag)
      else $error("receive flag set while disabled");

   c_rx_frame: cover property (rx_set);
   c_mp_reject: cover property (rx_done && !rx_set && ctrl_r.receiver_enable_control);
   c_tx_nine: cover property (tx_set && tx_nine_r);
   c_irq_rise: cover property ($rose(irq_out));
endmodule

// file: hdl/tick_divider.sv
// Divider that turns the system clock into a one-cycle enable pulse.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 135
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Enable pulse, one cycle in every DIV
   output logic      tick_out
);
   localparam int CW = $clog2(DIV);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          tick_nxt;

   if (DIV < 2) begin : g_bad_div
      $error("tick_divider: DIV must be at least 2");
   end

   // Count down so the compare is against a constant zero
   always_comb begin
      cnt_nxt  = cnt_r - 1'b1;
      tick_nxt = 1'b0;
      if (cnt_r == '0) begin
         cnt_nxt  = CW'(DIV - 1);
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r    <= CW'(DIV - 1);
         tick_out <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         tick_out <= tick_nxt;
      end
   end
endmodule

// file: pkg/serial_pkg.sv
// Shared constants and types of the serial port control and status block.
// Assumes one 250 MHz system clock and an Avalon-MM slave port with 32-bit data.
package serial_pkg;

   // Timing: oversampled bit clock derived from the system clock
   localparam int CLK_HZ    = 250_000_000;
   localparam int BAUD_HZ   = 115_200;
   localparam int OVS_RATE  = 16;
   localparam int OVS_DIV   = CLK_HZ / (BAUD_HZ * OVS_RATE);
   localparam logic [3:0] SUB_LAST = 4'hF;   // Last oversample slot of a bit
   localparam logic [3:0] SUB_MID  = 4'h7;   // Middle of the start bit
   localparam logic [3:0] DATA_LAST8 = 4'h7; // Index of the last data bit, 8-bit mode
   localparam logic [3:0] DATA_LAST9 = 4'h8; // Index of the last shifted bit, 9-bit mode

   // Register map: byte offsets on the slave port
   localparam logic [3:0] CTRL_OFS  = 4'h0;
   localparam logic [3:0] DATA_OFS  = 4'h4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int         DATA_BUSY_BIT = 8;

   // Control and status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic irq_enable;
      logic nine_bit_mode;
      logic multiprocessor_stop_check;
      logic receiver_enable_control;
      logic transmit_ninth_bit;
      logic receive_ninth_bit;
      logic transmit_complete_flag;
      logic receive_complete_flag;
   } ctrl_t;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'h0,
      TX_START = 3'h1,
      TX_DATA  = 3'h3,
      TX_NINTH = 3'h2,
      TX_STOP  = 3'h6
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h3,
      RX_STOP  = 2'h2
   } rx_state_t;

endpackage

// file: verification/remote_serial.sv
// Remote serial device: drives the receive line of the port and captures its transmit line.
// Assumes the port runs on clk_in with a bit time of BIT_CLKS clocks.
`timescale 1ns/1ps
module remote_serial #(
   parameter int BIT_CLKS = 32
) (
   // Clock and serial lines
   input  wire logic        clk_in,
   input  wire logic        txd_in,
   output logic             rxd_out,
   // Last captured frame, bit 0 first, and running frame count
   output logic      [10:0] frame_out,
   output logic      [7:0]  count_out
);
   // Line idles high as with a pull-up
   initial begin
      rxd_out = 1'h1;
      frame_out = 11'h000;
      count_out = 8'h00;
   end

   // Eleven samples from the middle of the start bit; in 8-bit frames the last one sees idle
   always begin : capture
      logic [10:0] bits;
      @(negedge txd_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 11; i++) begin
         bits[i] = txd_in;
         if (i < 10) begin
            repeat (BIT_CLKS) @(posedge clk_in);
         end
      end
      frame_out = bits;
      count_out = count_out + 8'h01;
   end

   // Send one frame; the last bit is cut to three quarters so a low stop cannot pass for a start
   task automatic send(input logic [7:0] d, input logic nine, input logic ninth, input logic stop);
      logic [10:0] f;
      int          n;
      f = nine ? {stop, ninth, d, 1'h0} : {1'h1, stop, d, 1'h0};
      n = nine ? 11 : 10;
      @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         rxd_out <= f[i];
         repeat (i == n - 1 ? BIT_CLKS * 3 / 4 : BIT_CLKS) @(posedge clk_in);
      end
      rxd_out <= 1'h1;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask
endmodule

// file: verification/serial_port_test.sv
// Self-checking bench of the serial port: register bus, receive filtering, transmit frames.
// Assumes the remote_serial model on the line and a short oversample divider for speed.
`timescale 1ns/1ps
module serial_port_test;
   localparam int OVS = 2;
   localparam int BIT_CLKS = 16 * OVS;

   // Bench signals
   logic        clk_in;
   logic        rst_in;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        rxd;
   logic        txd;
   logic        irq;
   logic [10:0] frame;
   logic [7:0]  count;
   int          fails;
   int          comparisons;

   // Byte enables stay on; lane 0 carries every writable field
   serial_port #(.OVS_DIV(OVS)) dut_u (
      .clk_in              (clk_in),
      .rst_in              (rst_in),
      .avs_address_in      (address),
      .avs_read_in         (read),
      .avs_write_in        (write),
      .avs_byteenable_in   (4'hF),
      .avs_writedata_in    (writedata),
      .avs_readdata_out    (readdata),
      .avs_waitrequest_out (waitrequest),
      .rxd_in              (rxd),
      .txd_out             (txd),
      .irq_out             (irq)
   );

   remote_serial #(.BIT_CLKS(BIT_CLKS)) partner_u (
      .clk_in    (clk_in),
      .txd_in    (txd),
      .rxd_out   (rxd),
      .frame_out (frame),
      .count_out (count)
   );

   // 250 MHz clock
   initial clk_in = 1'h0;
   always #2 clk_in = ~clk_in;

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One bus transfer; request held until waitrequest is sampled low, answer taken there
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= d;
      do begin
         @(posedge clk_in);
      end while (waitrequest !== 1'h0);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'h1, a, {24'h000000, d}, q);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      bus(1'h0, a, 32'h00000000, q);
   endtask

   // cfg = {nine, stop check, receive enable, prior ninth bit}; lin = {ninth, stop, accepted}
   task automatic rx_frame(input logic [3:0] cfg, input logic [7:0] d, input logic [2:0] lin);
      logic [31:0] q;
      logic [7:0]  prev;
      logic        rnb;
      rd(serial_pkg::DATA_OFS, q);
      prev = q[7:0];
      rnb = lin[0] ? (cfg[3] ? lin[2] : lin[1]) : cfg[0];
      wr(serial_pkg::CTRL_OFS, {1'h1, cfg[3:1], 1'h0, cfg[0], 2'h0});
      partner_u.send(d, cfg[3], lin[2], lin[1]);
      rd(serial_pkg::CTRL_OFS, q);
      check(32'(q[2:0]), 32'({rnb, 1'h0, lin[0]}), "rx ninth bit and flags");
      check(32'(irq), 32'(lin[0]), "irq after rx");
      rd(serial_pkg::DATA_OFS, q);
      check(32'(q[7:0]), 32'(lin[0] ? d : prev), "rx byte");
   endtask

   // Flag must still be clear just after the write and set once the frame is on the line
   task automatic tx_frame(input logic nine, input logic tnb, input logic [7:0] d);
      logic [31:0] q;
      logic [7:0]  c0;
      int          n;
      n = 0;
      q = 32'h00000100;
      // A data write while busy is dropped, so wait out the previous stop bit first
      while (q[8] !== 1'h0 && n < 40) begin
         rd(serial_pkg::DATA_OFS, q);
         n++;
      end
      check(32'(q[8]), 32'h00000000, "tx idle before frame");
      wr(serial_pkg::CTRL_OFS, {1'h1, nine, 2'h0, tnb, 3'h0});
      c0 = count;
      wr(serial_pkg::DATA_OFS, d);
      rd(serial_pkg::DATA_OFS, q);
      check(32'(q[8]), 32'h00000001, "tx busy after start");
      rd(serial_pkg::CTRL_OFS, q);
      check(32'(q[1]), 32'h00000000, "tx flag early");
      n = 0;
      while (count === c0 && n < 20 * BIT_CLKS) begin
         @(posedge clk_in);
         n++;
      end
      rd(serial_pkg::CTRL_OFS, q);
      check(32'(q[1]), 32'h00000001, "tx flag");
      check(32'(irq), 32'h00000001, "irq after tx");
      check(32'(frame), 32'({1'h1, nine ? tnb : 1'h1, d, 1'h0}), "tx frame");
   endtask

   task automatic test_reset;
      logic [31:0] q;
      rd(serial_pkg::CTRL_OFS, q);
      check(q, {24'h000000, serial_pkg::CTRL_RESET}, "control after reset");
      rd(serial_pkg::DATA_OFS, q);
      check(q, 32'h00000000, "data after reset");
      wr(4'h8, 8'hFF);
      rd(4'h8, q);
      check(q, 32'h00000000, "unmapped read");
      rd(serial_pkg::CTRL_OFS, q);
      check(q, 32'h00000000, "unmapped write");
   endtask

   task automatic test_stop_check;
      rx_frame(4'h2, 8'hA5, 3'h1);
      rx_frame(4'h6, 8'h3C, 3'h0);
      rx_frame(4'h6, 8'hC3, 3'h3);
   endtask

   task automatic test_multiproc;
      rx_frame(4'hB, 8'h5A, 3'h3);
      rx_frame(4'hE, 8'hC3, 3'h2);
      rx_frame(4'hE, 8'h81, 3'h7);
   endtask

   task automatic test_rx_disabled;
      rx_frame(4'h9, 8'h66, 3'h2);
      rx_frame(4'h0, 8'h99, 3'h2);
   endtask

   task automatic test_tx;
      tx_frame(1'h0, 1'h0, 8'h96);
      tx_frame(1'h1, 1'h0, 8'h69);
      tx_frame(1'h1, 1'h1, 8'hF0);
   endtask

   // Flag left set by the last frame must survive idle time, then mask and clear
   task automatic test_sticky;
      logic [31:0] q;
      repeat (4 * BIT_CLKS) @(posedge clk_in);
      rd(serial_pkg::CTRL_OFS, q);
      check(32'(q[1]), 32'h00000001, "tx flag held");
      wr(serial_pkg::CTRL_OFS, 8'h42);
      rd(serial_pkg::CTRL_OFS, q);
      check(32'(irq), 32'h00000000, "irq masked");
      wr(serial_pkg::CTRL_OFS, 8'h80);
      rd(serial_pkg::CTRL_OFS, q);
      check(32'({q[1:0], irq}), 32'h00000000, "flags cleared");
   endtask

   // Main sequence
   initial begin
      rst_in = 1'h1;
      read = 1'h0;
      write = 1'h0;
      address = 4'h0;
      writedata = 32'h00000000;
      fails = 0;
      comparisons = 0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'h0;
      test_reset;
      test_stop_check;
      test_multiproc;
      test_rx_disabled;
      test_tx;
      test_sticky;
      conclude;
   end

   // Watchdog; the whole sequence needs well under a quarter of this
   initial begin
      repeat (40000) @(posedge clk_in);
      fails++;
      conclude;
   end
endmodule
